// *** hdl/xsd_decode.sv ***
// data-space address decoder, paged register space and external moves
`timescale 1ns/100ps
`include "xsd_defines.svh"

module xsd_decode #(
    parameter int XD_BYTES = `XSD_XD_BYTES,
    parameter int XD_AW    = $clog2(XD_BYTES)
) (
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    // data-space access from the core
    input  wire logic        acc_valid_in,
    input  wire logic        acc_write_in,
    input  wire logic        acc_indirect_in,
    input  wire logic        acc_bit_in,
    input  wire logic [7:0]  acc_addr_in,
    input  wire logic [7:0]  acc_wdata_in,
    output logic      [7:0]  acc_rdata_out,
    output logic             acc_rvalid_out,
    // routed access towards internal ram and peripheral registers
    output logic             iram_sel_out,
    output logic             per_sel_out,
    output logic      [7:0]  per_page_out,
    output logic             tgt_write_out,
    output logic             tgt_bit_out,
    output logic      [2:0]  tgt_bitpos_out,
    output logic      [7:0]  tgt_addr_out,
    output logic      [7:0]  tgt_wdata_out,
    input  wire logic [7:0]  iram_rdata_in,
    input  wire logic [7:0]  per_rdata_in,
    // whole-pointer load and visible state
    input  wire logic        ptr_load_in,
    input  wire logic [15:0] ptr_load_value_in,
    output logic      [15:0] ptr_out,
    output logic      [7:0]  page_out,
    output logic             xpage_out,
    // external move
    input  wire logic        xm_valid_in,
    input  wire logic        xm_write_in,
    input  wire logic        xm_ptr_form_in,
    input  wire logic [7:0]  xm_index_in,
    input  wire logic [7:0]  xm_wdata_in,
    input  wire logic        flash_redirect_in,
    output logic      [7:0]  xm_rdata_out,
    output logic             xm_rvalid_out,
    output logic      [15:0] xm_addr_out,
    output logic             flash_wr_out,
    output logic      [15:0] flash_addr_out,
    output logic      [7:0]  flash_wdata_out
);

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    if (XD_BYTES < 256 || XD_BYTES > 65536 ||
        XD_BYTES != (1 << XD_AW)) begin : g_bad_size
        $error("ram size must be a power of two from 256 to 65536");
    end

    // ------------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------------
    // byte holding a bit address: upper bits sit in registers at x0/x8
    function automatic logic [7:0] bit_byte(input logic [7:0] a);
        bit_byte = a[7] ? {a[7:3], 3'h0}
                        : {`XSD_IRAM_BIT_BASE, a[6:3]};
    endfunction : bit_byte

    // registers that decode alike on every page
    function automatic logic is_shared(input logic [7:0] a);
        case (a)
            8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h90, 8'ha0, 8'ha7,
            8'ha8, 8'ha9, 8'hd0, 8'he0, 8'he5, 8'he6, 8'he7, 8'hf0,
            8'hf6, 8'hf7: is_shared = 1'b1;
            default:      is_shared = 1'b0;
        endcase
    endfunction : is_shared

    // registers kept inside this block
    function automatic logic is_local(input logic [7:0] a,
                                      input logic [7:0] pg);
        if (a == `XSD_ADDR_PAGE_REG) begin
            is_local = 1'b1;
        end else if (a == `XSD_ADDR_PTR_LOW || a == `XSD_ADDR_PTR_HIGH) begin
            is_local = 1'b1;
        end else if (a == `XSD_ADDR_XPAGE) begin
            is_local = (pg == `XSD_PAGE_BASE);
        end else begin
            is_local = 1'b0;
        end
    endfunction : is_local

    xsd_pkg::xsd_state_t    s_q;
    xsd_pkg::xsd_state_t    s_d;
    xsd_pkg::xsd_route_t    route;
    logic [7:0]             byte_addr;
    logic [7:0]             eff_page;
    logic [7:0]             local_rdata;
    logic [7:0]             read_byte;
    logic [15:0]            xm_eff;
    logic                   ram_wr;
    logic                   ram_rd;

    // ------------------------------------------------------------------
    // route the data-space access
    // ------------------------------------------------------------------
    always_comb begin
        byte_addr = acc_bit_in ? bit_byte(acc_addr_in) : acc_addr_in;
        eff_page  = is_shared(byte_addr) ? `XSD_PAGE_BASE
                                         : s_q.page;
        if (!acc_valid_in) begin
            route = xsd_pkg::XSD_ROUTE_NONE;
        end else if (!byte_addr[7] || acc_indirect_in) begin
            route = xsd_pkg::XSD_ROUTE_IRAM;
        end else if (is_local(byte_addr, eff_page)) begin
            route = xsd_pkg::XSD_ROUTE_LOCAL;
        end else begin
            route = xsd_pkg::XSD_ROUTE_PERIPH;
        end
    end

    assign iram_sel_out   = (route == xsd_pkg::XSD_ROUTE_IRAM);
    assign per_sel_out    = (route == xsd_pkg::XSD_ROUTE_PERIPH);
    assign per_page_out   = eff_page;
    assign tgt_write_out  = acc_write_in;
    assign tgt_bit_out    = acc_bit_in;
    assign tgt_bitpos_out = acc_addr_in[2:0];
    assign tgt_addr_out   = byte_addr;
    assign tgt_wdata_out  = acc_wdata_in;

    // ------------------------------------------------------------------
    // read data of the local registers
    // ------------------------------------------------------------------
    always_comb begin
        if (byte_addr == `XSD_ADDR_PAGE_REG) begin
            local_rdata = s_q.page;
        end else if (byte_addr == `XSD_ADDR_PTR_LOW) begin
            local_rdata = s_q.ptr[7:0];
        end else if (byte_addr == `XSD_ADDR_PTR_HIGH) begin
            local_rdata = s_q.ptr[15:8];
        end else begin
            local_rdata = {7'h00, s_q.xpage};
        end
    end

    // byte from whichever target answered
    always_comb begin
        case (route)
            xsd_pkg::XSD_ROUTE_IRAM:   read_byte = iram_rdata_in;
            xsd_pkg::XSD_ROUTE_LOCAL:  read_byte = local_rdata;
            xsd_pkg::XSD_ROUTE_PERIPH: read_byte = per_rdata_in;
            default:                   read_byte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // external-move address: pointer or page plus index
    // ------------------------------------------------------------------
    always_comb begin
        if (xm_ptr_form_in) begin
            xm_eff = s_q.ptr;
        end else begin
            xm_eff = {7'h00, s_q.xpage, xm_index_in};
        end
        ram_wr = xm_valid_in && xm_write_in && !flash_redirect_in;
        ram_rd = xm_valid_in && !xm_write_in;
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d           = s_q;
        s_d.rvalid    = acc_valid_in && !acc_write_in;
        s_d.xm_rvalid = ram_rd;
        s_d.flash_wr  = xm_valid_in && xm_write_in && flash_redirect_in;
        if (acc_valid_in && !acc_write_in) begin
            s_d.rdata = acc_bit_in
                      ? {7'h00, read_byte[acc_addr_in[2:0]]}
                      : read_byte;
        end
        if (xm_valid_in) begin
            s_d.xm_addr = xm_eff;
        end
        if (s_d.flash_wr) begin
            s_d.flash_addr  = xm_eff;
            s_d.flash_wdata = xm_wdata_in;
        end
        // local register writes; a whole-pointer load wins over a byte
        if (route == xsd_pkg::XSD_ROUTE_LOCAL && acc_write_in) begin
            if (byte_addr == `XSD_ADDR_PAGE_REG) begin
                s_d.page = acc_wdata_in;
            end else if (byte_addr == `XSD_ADDR_PTR_LOW) begin
                s_d.ptr[7:0] = acc_wdata_in;
            end else if (byte_addr == `XSD_ADDR_PTR_HIGH) begin
                s_d.ptr[15:8] = acc_wdata_in;
            end else begin
                s_d.xpage = acc_wdata_in[`XSD_XPAGE_BIT];
            end
        end
        if (ptr_load_in) begin
            s_d.ptr = ptr_load_value_in;
        end
    end

    // state register
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            s_q       <= '0;
            s_q.page  <= `XSD_RST_PAGE;
            s_q.xpage <= `XSD_RST_XPAGE;
            s_q.ptr   <= `XSD_RST_PTR;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // external-data ram, aliased on the low address bits
    // ------------------------------------------------------------------
    xsd_xdram #(
        .DEPTH (XD_BYTES),
        .AW    (XD_AW)
    ) u_ram (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .wr_en_in  (ram_wr),
        .rd_en_in  (ram_rd),
        .addr_in   (xm_eff[XD_AW-1:0]),
        .wdata_in  (xm_wdata_in),
        .rdata_out (xm_rdata_out)
    );

    assign acc_rdata_out   = s_q.rdata;
    assign acc_rvalid_out  = s_q.rvalid;
    assign ptr_out         = s_q.ptr;
    assign page_out        = s_q.page;
    assign xpage_out       = s_q.xpage;
    assign xm_rvalid_out   = s_q.xm_rvalid;
    assign xm_addr_out     = s_q.xm_addr;
    assign flash_wr_out    = s_q.flash_wr;
    assign flash_addr_out  = s_q.flash_addr;
    assign flash_wdata_out = s_q.flash_wdata;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_xpage_write;
        acc_valid_in && acc_write_in && !acc_indirect_in && !acc_bit_in &&
        acc_addr_in == `XSD_ADDR_XPAGE && s_q.page == `XSD_PAGE_BASE;
    endsequence

    sequence s_index_move;
        xm_valid_in && !xm_ptr_form_in;
    endsequence

    chk_xpage_next_move: assert property (@(posedge mclk_in)
        disable iff (reset_in)
        s_xpage_write ##1 s_index_move |=>
            xm_addr_out[8] == $past(acc_wdata_in[0], 2) &&
            xm_addr_out[15:9] == 7'h00)
        else $error("page write not applied to next external move");
    chk_xpage_read_zero: assert property (@(posedge mclk_in)
        disable iff (reset_in)
        acc_valid_in && !acc_write_in && route == xsd_pkg::XSD_ROUTE_LOCAL &&
        byte_addr == `XSD_ADDR_XPAGE |=> acc_rdata_out[7:1] == 7'h00)
        else $error("page register upper bits not zero");
    chk_ptr_move_addr: assert property (@(posedge mclk_in)
        disable iff (reset_in)
        xm_valid_in && xm_ptr_form_in |=> xm_addr_out == $past(ptr_out))
        else $error("pointer move address wrong");
    chk_index_move_addr: assert property (@(posedge mclk_in)
        disable iff (reset_in)
        s_index_move |=> xm_addr_out[7:0] == $past(xm_index_in) &&
            xm_addr_out[8] == $past(xpage_out))
        else $error("index move address wrong");
    chk_ptr_high_byte: assert property (@(posedge mclk_in)
        disable iff (reset_in)
        route == xsd_pkg::XSD_ROUTE_LOCAL && acc_write_in && !ptr_load_in &&
        byte_addr == `XSD_ADDR_PTR_HIGH |=>
            ptr_out[15:8] == $past(acc_wdata_in) &&
            ptr_out[7:0] == $past(ptr_out[7:0]))
        else $error("pointer high byte write wrong");
    chk_direct_upper: assert property (@(posedge mclk_in)
        disable iff (reset_in)
        acc_valid_in && !acc_indirect_in && byte_addr[7] |->
            !iram_sel_out)
        else $error("direct upper access reached internal ram");
    chk_indirect_upper: assert property (@(posedge mclk_in)
        disable iff (reset_in)
        acc_valid_in && acc_indirect_in |-> iram_sel_out && !per_sel_out)
        else $error("indirect access left internal ram");
    chk_shared_page: assert property (@(posedge mclk_in)
        disable iff (reset_in)
        per_sel_out && is_shared(tgt_addr_out) |->
            per_page_out == `XSD_PAGE_BASE)
        else $error("shared register decoded on wrong page");
    chk_reset_pages: assert property (@(posedge mclk_in)
        reset_in |=> page_out == `XSD_RST_PAGE && !xpage_out &&
            !xm_rvalid_out && !flash_wr_out)
        else $error("page registers not cleared by reset");
    chk_bit_boundary: assert property (@(posedge mclk_in)
        disable iff (reset_in)
        acc_valid_in && acc_bit_in && per_sel_out |->
            tgt_addr_out[2:0] == 3'h0)
        else $error("bit access off an x0 or x8 address");
    chk_move_timing: assert property (@(posedge mclk_in)
        disable iff (reset_in)
        xm_valid_in && !xm_write_in |=> xm_rvalid_out ##1
            (!xm_rvalid_out || $past(xm_valid_in && !xm_write_in)))
        else $error("external move read not answered in one cycle");
    chk_ram_default: assert property (@(posedge mclk_in)
        disable iff (reset_in)
        xm_valid_in && xm_write_in && !flash_redirect_in |=> !flash_wr_out)
        else $error("external write left ram without redirect");

endmodule : xsd_decode

// *** hdl/xsd_defines.svh ***
// constants of the data-space address decoder and external-move path
`ifndef XSD_DEFINES_SVH
`define XSD_DEFINES_SVH

// ----------------------------------------------------------------------
// register addresses in the direct upper space
// ----------------------------------------------------------------------
`define XSD_ADDR_PAGE_REG   8'ha7
`define XSD_ADDR_XPAGE      8'haa
`define XSD_ADDR_PTR_LOW    8'h82
`define XSD_ADDR_PTR_HIGH   8'h83

// ----------------------------------------------------------------------
// pages, space limits and field positions
// ----------------------------------------------------------------------
`define XSD_PAGE_BASE       8'h00
`define XSD_PAGE_ALT        8'h0f
`define XSD_IRAM_BIT_BASE   4'h2
`define XSD_XPAGE_BIT       0

// ----------------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------------
`define XSD_RST_PAGE        8'h00
`define XSD_RST_XPAGE       1'b0
`define XSD_RST_PTR         16'h0000
`define XSD_XD_BYTES        512

`endif

// *** hdl/xsd_pkg.sv ***
// types shared by the decoder and its external-data ram
package xsd_pkg;

    // ------------------------------------------------------------------
    // where one data-space access goes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        XSD_ROUTE_NONE,
        XSD_ROUTE_IRAM,
        XSD_ROUTE_LOCAL,
        XSD_ROUTE_PERIPH
    } xsd_route_t;

    // ------------------------------------------------------------------
    // state of the decoder
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  page;
        logic        xpage;
        logic [15:0] ptr;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        xm_rvalid;
        logic [15:0] xm_addr;
        logic        flash_wr;
        logic [15:0] flash_addr;
        logic [7:0]  flash_wdata;
    } xsd_state_t;

    // ------------------------------------------------------------------
    // state of the external-data ram besides its array
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] rdata;
    } xsd_ram_state_t;

endpackage : xsd_pkg

// *** hdl/xsd_xdram.sv ***
// byte-wide on-chip external-data ram with registered read
`timescale 1ns/100ps

module xsd_xdram #(
    parameter int DEPTH = 512,
    parameter int AW    = 9
) (
    input  wire logic          mclk_in,
    input  wire logic          reset_in,
    input  wire logic          wr_en_in,
    input  wire logic          rd_en_in,
    input  wire logic [AW-1:0] addr_in,
    input  wire logic [7:0]    wdata_in,
    output logic      [7:0]    rdata_out
);

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    if (DEPTH != (1 << AW)) begin : g_bad_depth
        $error("ram depth must be two to the power of the address width");
    end

    logic [7:0]                 mem [DEPTH];
    xsd_pkg::xsd_ram_state_t    s_q;
    xsd_pkg::xsd_ram_state_t    s_d;

    // ------------------------------------------------------------------
    // next state: read data holds until the next read
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (rd_en_in) begin
            s_d.rdata = mem[addr_in];
        end
    end

    // no setup needed: the array is usable from the first access
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
        if (wr_en_in) begin
            mem[addr_in] <= wdata_in;
        end
    end

    assign rdata_out = s_q.rdata;

endmodule : xsd_xdram

// *** testbench/external_data_ram_sfr_address_decode_bench.sv ***
// self-checking bench of the data-space decoder
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin \
 $display("[FAIL] %0t got %h exp %h", $time, a, b); \
 fail_count++; end end

module external_data_ram_sfr_address_decode_bench;
    logic        mclk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        av = 1'b0, aw = 1'b0, ai = 1'b0, ab = 1'b0;
    logic [7:0]  aa = 8'h00, ad = 8'h00, idx = 8'h00, xd = 8'h00;
    logic        pl = 1'b0, xv = 1'b0, xw = 1'b0, xp = 1'b0, fr = 1'b0;
    logic [15:0] plv = 16'h0000;
    logic [7:0]  rd, xrd, pg, ta, tw, ir, pr, fwd;
    logic        rv, isel, psel, tr, tb, xpg, xrv, fwr;
    logic [2:0]  bp;
    logic [15:0] ptr, xa, fa;
    logic        c_i, c_p;
    logic [7:0]  c_pg, c_ta;
    logic [7:0]  fwd_d;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cyc = 0;

    // ------------------------------------------------------------------
    // clock, timeout and instances
    // ------------------------------------------------------------------
    initial begin
        forever #25 mclk_in = ~mclk_in;
    end

    // cut a hang short
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            end_sim();
        end
    end

    xsd_target_model TGT (.iram_sel_in(isel), .per_sel_in(psel),
        .addr_in(ta), .iram_rdata_out(ir), .per_rdata_out(pr));

    xsd_decode DUT (.mclk_in(mclk_in), .reset_in(reset_in),
        .acc_valid_in(av), .acc_write_in(aw), .acc_indirect_in(ai),
        .acc_bit_in(ab), .acc_addr_in(aa), .acc_wdata_in(ad),
        .acc_rdata_out(rd), .acc_rvalid_out(rv), .iram_sel_out(isel),
        .per_sel_out(psel), .per_page_out(pg), .tgt_write_out(tr),
        .tgt_bit_out(tb), .tgt_bitpos_out(bp), .tgt_addr_out(ta),
        .tgt_wdata_out(tw), .iram_rdata_in(ir), .per_rdata_in(pr),
        .ptr_load_in(pl), .ptr_load_value_in(plv), .ptr_out(ptr),
        .page_out(fwd), .xpage_out(xpg), .xm_valid_in(xv),
        .xm_write_in(xw), .xm_ptr_form_in(xp), .xm_index_in(idx),
        .xm_wdata_in(xd), .flash_redirect_in(fr), .xm_rdata_out(xrd),
        .xm_rvalid_out(xrv), .xm_addr_out(xa), .flash_wr_out(fwr),
        .flash_addr_out(fa), .flash_wdata_out(fwd_d));

    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    // one data-space access; comb routing captured in the request cycle
    task automatic acc(input logic w, i, b, input logic [7:0] a, d);
        @(posedge mclk_in);
        av <= 1'b1;
        aw <= w;
        ai <= i;
        ab <= b;
        aa <= a;
        ad <= d;
        #1;
        c_i = isel;
        c_p = psel;
        c_pg = pg;
        c_ta = ta;
        @(posedge mclk_in);
        av <= 1'b0;
        #1;
        `CHK(rv, ~w)
    endtask : acc

    // one external move
    task automatic xm(input logic w, f, input logic [7:0] x, d);
        @(posedge mclk_in);
        xv <= 1'b1;
        xw <= w;
        xp <= f;
        idx <= x;
        xd <= d;
        @(posedge mclk_in);
        xv <= 1'b0;
        #1;
    endtask : xm

    // whole-pointer load
    task automatic ld(input logic [15:0] v);
        @(posedge mclk_in);
        pl <= 1'b1;
        plv <= v;
        @(posedge mclk_in);
        pl <= 1'b0;
    endtask : ld

    task automatic end_sim;
        if (fail_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk_in);
        reset_in <= 1'b0;
        #1;
        `CHK({fwd, xpg, ptr}, 25'h0)
        acc(0, 0, 0, 8'haa, 8'h00);
        `CHK(rd, 8'h00)
        acc(0, 0, 0, 8'ha7, 8'h00);
        `CHK(rd, 8'h00)
        // upper page-bits ignored
        acc(1, 0, 0, 8'haa, 8'hfe);
        acc(0, 0, 0, 8'haa, 8'h00);
        `CHK(rd, 8'h00)
        acc(1, 0, 0, 8'haa, 8'hff);
        acc(0, 0, 0, 8'haa, 8'h00);
        `CHK(rd, 8'h01)
        `CHK(xpg, 1'b1)
        // pointer bytes
        acc(1, 0, 0, 8'h82, 8'h34);
        acc(1, 0, 0, 8'h83, 8'h12);
        `CHK(ptr, 16'h1234)
        acc(0, 0, 0, 8'h83, 8'h00);
        `CHK(rd, 8'h12)
        // both ram pages hold distinct data
        ld(16'h01ff);
        xm(1, 1, 8'h00, 8'ha1);
        ld(16'h00ff);
        xm(1, 1, 8'h00, 8'hb2);
        ld(16'h01ff);
        xm(0, 1, 8'h00, 8'h00);
        `CHK({xrv, xrd, xa}, 25'h1a101ff)
        ld(16'h00ff);
        xm(0, 1, 8'h00, 8'h00);
        `CHK(xrd, 8'hb2)
        // high pointer bits alias onto the ram
        ld(16'h13ff);
        xm(0, 1, 8'h00, 8'h00);
        `CHK(xrd, 8'ha1)
        // index form on page bit 1, then page 0 right after the write
        xm(0, 0, 8'hff, 8'h00);
        `CHK({xrd, xa}, 24'ha101ff)
        acc(1, 0, 0, 8'haa, 8'h00);
        xm(0, 0, 8'hff, 8'h00);
        `CHK({xrd, xa}, 24'hb200ff)
        // page bit write with an index move in the very next cycle
        @(posedge mclk_in);
        {av, aw, aa, ad} <= {2'b11, 8'haa, 8'h01};
        @(posedge mclk_in);
        av <= 1'b0;
        {xv, xw, xp, idx} <= {3'b100, 8'hff};
        @(posedge mclk_in);
        xv <= 1'b0;
        #1;
        `CHK({xrd, xa}, 24'ha101ff)
        // redirected write leaves ram alone
        @(posedge mclk_in);
        fr <= 1'b1;
        xm(1, 0, 8'hff, 8'h77);
        `CHK({fwr, fa, fwd_d}, 25'h101ff77)
        @(posedge mclk_in);
        fr <= 1'b0;
        xm(0, 0, 8'hff, 8'h00);
        `CHK(xrd, 8'ha1)
        // routing by addressing mode
        acc(0, 0, 0, 8'h90, 8'h00);
        `CHK({c_i, c_p, c_pg, rd}, 18'h100ca)
        acc(0, 1, 0, 8'h90, 8'h00);
        `CHK({c_i, c_p, rd}, 10'h26f)
        // bit access: register and internal-ram bit spaces
        acc(0, 0, 1, 8'h93, 8'h00);
        `CHK({c_p, c_ta, bp, rd}, 20'hc8301)
        acc(0, 0, 1, 8'h11, 8'h00);
        `CHK({c_i, c_ta, rd}, 17'h12200)
        // page 0xf: paged registers and 0xaa decode on it, shared ones and the page and pointer registers do not
        acc(1, 0, 0, 8'ha7, 8'h0f);
        acc(0, 0, 0, 8'hb9, 8'h00);
        `CHK({c_p, c_pg}, 9'h10f)
        acc(1, 0, 0, 8'hb9, 8'h3c);
        `CHK({c_p, tr, tb, tw}, 11'h63c)
        acc(0, 0, 0, 8'he0, 8'h00);
        `CHK({c_p, c_pg}, 9'h100)
        acc(0, 0, 0, 8'h82, 8'h00);
        `CHK({c_p, rd}, 9'h0ff)
        acc(0, 0, 0, 8'ha7, 8'h00);
        `CHK(rd, 8'h0f)
        acc(0, 0, 0, 8'haa, 8'h00);
        `CHK(c_p, 1'b1)
        // reset in mid-run clears the registers again
        @(posedge mclk_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        reset_in <= 1'b0;
        #1;
        `CHK({fwd, xpg, ptr, xrd}, 33'h0)
        acc(1, 0, 0, 8'ha7, 8'h00);
        end_sim();
    end
endmodule : external_data_ram_sfr_address_decode_bench

// *** testbench/xsd_target_model.sv ***
// model of internal ram and peripheral register read data
`timescale 1ns/100ps

module xsd_target_model (
    input  wire logic       iram_sel_in,
    input  wire logic       per_sel_in,
    input  wire logic [7:0] addr_in,
    output logic      [7:0] iram_rdata_out,
    output logic      [7:0] per_rdata_out
);
    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    // unselected targets show the address, plain from internal ram and inverted from peripherals, never a stale value
    assign iram_rdata_out = iram_sel_in ? ~addr_in : addr_in;
    assign per_rdata_out  = per_sel_in ? addr_in ^ 8'h5a : ~addr_in;
endmodule : xsd_target_model
